// *** fpp_flash_guard.sv ***
`timescale 1ns/1ps
`default_nettype none
module fpp_flash_guard #(
  parameter int BIT_CYC = fpp_pkg::BIT_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic boot_mode_select_pin,
  input wire logic program_select_input,
  input wire logic port3_bit2,
  input wire logic serial_clock_2_pin,
  input wire logic port0_bit4,
  output logic serial_out_2_pin,
  output logic port0_bit7,
  input wire logic [7:0] prot_ctrl_byte,
  input wire logic [55:0] stored_id,
  input wire logic flash_blank,
  input wire logic par_req,
  input wire logic [1:0] par_op,
  input wire logic par_boot_sel,
  input wire logic [15:0] par_addr,
  output logic par_grant,
  output logic par_refuse,
  output logic [15:0] erase_base,
  output logic [15:0] erase_top,
  input wire logic test_read_req,
  output logic test_grant,
  output logic test_refuse,
  input wire logic ser_wr_req,
  input wire logic [15:0] ser_wr_addr,
  output logic ser_wr_grant,
  output logic ser_wr_refuse,
  output logic cmd_valid,
  output logic [7:0] cmd_byte,
  input wire logic cmd_ack,
  output logic id_reject,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata
);
  import fpp_pkg::*;

  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  if (int'(BOOT_TOP) - int'(BOOT_BASE) + 1 != BOOT_BYTES) begin : g_bad_boot
    $error("boot area size mismatch");
  end
  if (int'(ID_LAST) - int'(ID_FIRST) + 1 != ID_BYTES) begin : g_bad_id
    $error("identifier span mismatch");
  end

  fpp_mode_e mode_reg;
  fpp_ser_e ser_reg;
  logic [3:0] strap_reg;
  logic in_rst_reg;
  logic [7:0] prot_byte_reg;
  logic [7:0] ctrl_reg;
  logic tx_start_reg;
  logic [7:0] tx_byte_reg;
  logic [2:0] id_cnt_reg;
  logic id_good_reg;
  logic id_ok_reg;
  logic pend_reg;
  logic rx_valid;
  logic [7:0] rx_byte;
  logic tx_busy;
  logic l1_sel;
  logic l2_sel;
  logic prot_on;
  fpp_prot_e level;
  logic id_match;
  logic unprot_write;
  logic boot_range_bad;

  // ----------------------------------------
  // mode entry at reset release
  // ----------------------------------------

  // straps tracked while reset is held
  always_ff @(posedge clk) begin
    if (rst) begin
      strap_reg <= {boot_mode_select_pin, program_select_input, port3_bit2, serial_clock_2_pin};
      in_rst_reg <= 1'b1;
    end else begin
      in_rst_reg <= 1'b0;
    end
  end

  // mode decided at the first edge after release
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_reg <= FPP_MODE_USER;
    end else if (in_rst_reg) begin
      // mode pin must already be high
      if (!strap_reg[3]) begin
        // mode pin low keeps normal mode
        mode_reg <= FPP_MODE_USER;
      end else if (!strap_reg[2] && strap_reg[1] && !strap_reg[0]) begin
        mode_reg <= FPP_MODE_SERIAL;
      end else if (strap_reg[2]) begin
        mode_reg <= FPP_MODE_PARALLEL;
      end else begin
        mode_reg <= FPP_MODE_USER;
      end
    end
  end

  // ----------------------------------------
  // protect decode
  // ----------------------------------------

  // protect byte as read from flash
  always_ff @(posedge clk) begin
    if (rst) begin
      prot_byte_reg <= 8'hFF;
    end else begin
      prot_byte_reg <= prot_ctrl_byte;
    end
  end

  assign l1_sel = ~prot_byte_reg[PROT_L1_BIT];
  assign l2_sel = ~prot_byte_reg[PROT_L2_BIT];
  // unprotect bits 00 turn it off
  assign prot_on = (l1_sel | l2_sel) && {prot_byte_reg[UNPROT_HI_BIT], prot_byte_reg[UNPROT_LO_BIT]} != 2'b00;

  // level selection
  always_comb begin
    level = FPP_PROT_OFF;
    if (prot_on) begin
      if (l2_sel) begin
        level = FPP_PROT_L2;
      end else begin
        level = FPP_PROT_L1;
      end
    end
  end

  // ----------------------------------------
  // parallel access gate
  // ----------------------------------------

  assign unprot_write = prot_on && par_op != OP_READ && par_addr == PROT_ADDR;
  assign boot_range_bad = par_boot_sel && par_addr < BOOT_BASE;

  // grant or refuse each parallel request
  always_ff @(posedge clk) begin
    if (rst) begin
      par_grant <= 1'b0;
      par_refuse <= 1'b0;
      erase_base <= 16'h0000;
      erase_top <= 16'h0000;
    end else begin
      par_grant <= 1'b0;
      par_refuse <= 1'b0;
      if (par_req) begin
        if (mode_reg != FPP_MODE_PARALLEL || prot_on || unprot_write || boot_range_bad) begin
          par_refuse <= 1'b1;
        end else begin
          par_grant <= 1'b1;
          if (par_op == OP_ERASE) begin
            if (par_boot_sel) begin
              erase_base <= BOOT_BASE;
              erase_top <= BOOT_TOP;
            end else begin
              erase_base <= par_addr;
              erase_top <= par_addr;
            end
          end
        end
      end
    end
  end

  // factory test readout gate
  always_ff @(posedge clk) begin
    if (rst) begin
      test_grant <= 1'b0;
      test_refuse <= 1'b0;
    end else begin
      test_grant <= test_read_req && level != FPP_PROT_L2;
      test_refuse <= test_read_req && level == FPP_PROT_L2;
    end
  end

  // ----------------------------------------
  // serial link
  // ----------------------------------------

  fpp_byte_link #(
    .BIT_CYC(BIT_CYC)
  ) u_link (
    .clk(clk),
    .rst(rst),
    .variant_async(ctrl_reg[CTRL_VARIANT_BIT]),
    .sclk(serial_clock_2_pin),
    .rxd(port0_bit4),
    .txd(serial_out_2_pin),
    .rx_valid(rx_valid),
    .rx_byte(rx_byte),
    .tx_start(tx_start_reg),
    .tx_byte(tx_byte_reg),
    .tx_busy(tx_busy)
  );

  // byte i sits at first address plus i
  assign id_match = rx_byte == stored_id[8*id_cnt_reg +: 8];

  // identifier check, then command stream
  always_ff @(posedge clk) begin
    if (rst || mode_reg != FPP_MODE_SERIAL) begin
      ser_reg <= FPP_SER_ID;
      id_cnt_reg <= 3'h0;
      id_good_reg <= 1'b1;
      id_ok_reg <= 1'b0;
      id_reject <= 1'b0;
      cmd_valid <= 1'b0;
      cmd_byte <= 8'h00;
    end else begin
      id_reject <= 1'b0;
      cmd_valid <= 1'b0;
      case (ser_reg)
        FPP_SER_ID: begin
          if (flash_blank) begin
            ser_reg <= FPP_SER_CMD;
            id_ok_reg <= 1'b1;
          end else if (rx_valid) begin
            if (id_cnt_reg == 3'(ID_BYTES - 1)) begin
              id_cnt_reg <= 3'h0;
              id_good_reg <= 1'b1;
              if (id_good_reg && id_match) begin
                ser_reg <= FPP_SER_CMD;
                id_ok_reg <= 1'b1;
              end else begin
                id_reject <= 1'b1;
              end
            end else begin
              id_cnt_reg <= id_cnt_reg + 3'h1;
              id_good_reg <= id_good_reg & id_match;
            end
          end
        end
        FPP_SER_CMD: begin
          if (rx_valid) begin
            cmd_valid <= 1'b1;
            cmd_byte <= rx_byte;
          end
        end
        default: begin
          ser_reg <= FPP_SER_ID;
        end
      endcase
    end
  end

  // pending command, new byte wins over ack
  always_ff @(posedge clk) begin
    if (rst) begin
      pend_reg <= 1'b0;
    end else if (rx_valid && ser_reg == FPP_SER_CMD && mode_reg == FPP_MODE_SERIAL) begin
      pend_reg <= 1'b1;
    end else if (cmd_ack) begin
      pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      port0_bit7 <= 1'b0;
    end else begin
      port0_bit7 <= mode_reg == FPP_MODE_SERIAL && (pend_reg || tx_busy || tx_start_reg);
    end
  end

  // user area write gate in serial mode
  always_ff @(posedge clk) begin
    if (rst) begin
      ser_wr_grant <= 1'b0;
      ser_wr_refuse <= 1'b0;
    end else begin
      ser_wr_grant <= ser_wr_req && mode_reg == FPP_MODE_SERIAL && id_ok_reg && ser_wr_addr < BOOT_BASE;
      ser_wr_refuse <= ser_wr_req && !(mode_reg == FPP_MODE_SERIAL && id_ok_reg && ser_wr_addr < BOOT_BASE);
    end
  end

  // ----------------------------------------
  // register port
  // ----------------------------------------

  // control and transmit writes
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_reg <= CTRL_RST;
      tx_start_reg <= 1'b0;
      tx_byte_reg <= 8'h00;
    end else begin
      tx_start_reg <= 1'b0;
      if (reg_wr && reg_addr == REG_CTRL) begin
        ctrl_reg <= {7'h00, reg_wdata[CTRL_VARIANT_BIT]};
      end
      if (reg_wr && reg_addr == REG_TXDATA) begin
        tx_start_reg <= 1'b1;
        tx_byte_reg <= reg_wdata;
      end
    end
  end

  // read data one cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        REG_STATUS: begin
          reg_rdata <= 8'h00;
          reg_rdata[ST_MODE_LSB +: 2] <= mode_reg;
          reg_rdata[ST_LEVEL_LSB +: 2] <= level;
          reg_rdata[ST_ID_OK_BIT] <= id_ok_reg;
          reg_rdata[ST_BUSY_BIT] <= port0_bit7;
          reg_rdata[ST_ID_WAIT_BIT] <= ser_reg == FPP_SER_ID;
        end
        REG_CTRL: begin
          reg_rdata <= ctrl_reg;
        end
        default: begin
          reg_rdata <= 8'h00; // unmapped and transmit read as zero
        end
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule // fpp_flash_guard
`default_nettype wire

// *** fpp_pkg.sv ***
package fpp_pkg;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_HZ = 25_000_000;
  localparam int BAUD_HZ = 9600;
  localparam int BIT_CYC = CLK_HZ / BAUD_HZ;

  // ----------------------------------------
  // flash map
  // ----------------------------------------
  localparam logic [15:0] BOOT_BASE = 16'hF000;
  localparam logic [15:0] BOOT_TOP = 16'hFFFF;
  localparam int BOOT_BYTES = 4096;
  localparam logic [15:0] PROT_ADDR = 16'hFFDB;
  localparam logic [15:0] ID_FIRST = 16'hFFD4;
  localparam logic [15:0] ID_LAST = 16'hFFDA;
  localparam int ID_BYTES = 7;

  // ----------------------------------------
  // protect control byte fields
  // ----------------------------------------
  localparam int PROT_L1_BIT = 0;
  localparam int PROT_L2_BIT = 1;
  localparam int UNPROT_LO_BIT = 2;
  localparam int UNPROT_HI_BIT = 3;

  // ----------------------------------------
  // parallel operations
  // ----------------------------------------
  localparam logic [1:0] OP_READ = 2'h0;
  localparam logic [1:0] OP_PROG = 2'h1;
  localparam logic [1:0] OP_ERASE = 2'h2;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_CTRL = 8'h04;
  localparam logic [7:0] REG_TXDATA = 8'h08;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam int CTRL_VARIANT_BIT = 0;
  localparam int ST_MODE_LSB = 0;
  localparam int ST_LEVEL_LSB = 2;
  localparam int ST_ID_OK_BIT = 4;
  localparam int ST_BUSY_BIT = 5;
  localparam int ST_ID_WAIT_BIT = 6;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {FPP_MODE_USER, FPP_MODE_PARALLEL, FPP_MODE_SERIAL} fpp_mode_e;
  typedef enum logic [1:0] {FPP_PROT_OFF, FPP_PROT_L1, FPP_PROT_L2} fpp_prot_e;
  typedef enum logic {FPP_SER_ID, FPP_SER_CMD} fpp_ser_e;

endpackage

// *** fpp_byte_link.sv ***
`timescale 1ns/1ps
`default_nettype none
module fpp_byte_link #(
  parameter int BIT_CYC = 2604
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic variant_async,
  input wire logic sclk,
  input wire logic rxd,
  output logic txd,
  output logic rx_valid,
  output logic [7:0] rx_byte,
  input wire logic tx_start,
  input wire logic [7:0] tx_byte,
  output logic tx_busy
);

  localparam int CW = $clog2(BIT_CYC + 1);

  // ----------------------------------------
  // elaboration check
  // ----------------------------------------
  if (BIT_CYC < 4) begin : g_bad_cyc
    $error("bit period too short");
  end

  logic sclk_d_reg;
  logic [7:0] rx_sh_reg;
  logic [3:0] rx_bit_reg;
  logic [CW-1:0] rx_cnt_reg;
  logic rx_act_reg;
  logic [9:0] tx_sh_reg;
  logic [3:0] tx_left_reg;
  logic [CW-1:0] tx_cnt_reg;
  logic sclk_rise;
  logic sclk_fall;

  // serial clock edges
  always_ff @(posedge clk) begin
    if (rst) begin
      sclk_d_reg <= 1'b0;
    end else begin
      sclk_d_reg <= sclk;
    end
  end
  assign sclk_rise = sclk & ~sclk_d_reg;
  assign sclk_fall = ~sclk & sclk_d_reg;

  // receiver, lsb first in both variants
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_sh_reg <= 8'h00;
      rx_bit_reg <= 4'h0;
      rx_cnt_reg <= '0;
      rx_act_reg <= 1'b0;
      rx_valid <= 1'b0;
      rx_byte <= 8'h00;
    end else begin
      rx_valid <= 1'b0;
      if (!variant_async) begin
        if (sclk_rise) begin
          rx_sh_reg <= {rxd, rx_sh_reg[7:1]};
          if (rx_bit_reg == 4'h7) begin
            rx_bit_reg <= 4'h0;
            rx_valid <= 1'b1;
            rx_byte <= {rxd, rx_sh_reg[7:1]};
          end else begin
            rx_bit_reg <= rx_bit_reg + 4'h1;
          end
        end
      end else if (!rx_act_reg) begin
        if (!rxd) begin
          rx_act_reg <= 1'b1;
          rx_bit_reg <= 4'h0;
          rx_cnt_reg <= CW'(BIT_CYC / 2);
        end
      end else if (rx_cnt_reg != '0) begin
        rx_cnt_reg <= rx_cnt_reg - CW'(1);
      end else begin
        rx_cnt_reg <= CW'(BIT_CYC - 1);
        rx_bit_reg <= rx_bit_reg + 4'h1;
        if (rx_bit_reg == 4'h0 && rxd) begin
          rx_act_reg <= 1'b0; // false start
        end else if (rx_bit_reg == 4'h9) begin
          rx_act_reg <= 1'b0;
          rx_valid <= rxd; // framing error drops byte
          rx_byte <= rx_sh_reg;
        end else if (rx_bit_reg != 4'h0) begin
          rx_sh_reg <= {rxd, rx_sh_reg[7:1]};
        end
      end
    end
  end

  // transmitter
  always_ff @(posedge clk) begin
    if (rst) begin
      txd <= 1'b1;
      tx_sh_reg <= 10'h3FF;
      tx_left_reg <= 4'h0;
      tx_cnt_reg <= '0;
    end else if (tx_start && tx_left_reg == 4'h0) begin
      if (!variant_async) begin
        txd <= tx_byte[0];
        tx_sh_reg <= {3'h7, tx_byte[7:1]};
        tx_left_reg <= 4'h7;
      end else begin
        tx_sh_reg <= {1'b1, tx_byte, 1'b0};
        tx_left_reg <= 4'hA;
        tx_cnt_reg <= '0;
      end
    end else if (tx_left_reg != 4'h0) begin
      if (!variant_async) begin
        if (sclk_fall) begin
          txd <= tx_sh_reg[0];
          tx_sh_reg <= {1'b1, tx_sh_reg[9:1]};
          tx_left_reg <= tx_left_reg - 4'h1;
        end
      end else if (tx_cnt_reg != '0) begin
        tx_cnt_reg <= tx_cnt_reg - CW'(1);
      end else begin
        txd <= tx_sh_reg[0];
        tx_sh_reg <= {1'b1, tx_sh_reg[9:1]};
        tx_left_reg <= tx_left_reg - 4'h1;
        tx_cnt_reg <= CW'(BIT_CYC - 1);
      end
    end else if (tx_cnt_reg != '0) begin
      tx_cnt_reg <= tx_cnt_reg - CW'(1); // stop bit time
    end
  end
  assign tx_busy = (tx_left_reg != 4'h0) || (tx_cnt_reg != '0);

endmodule // fpp_byte_link
`default_nettype wire

// *** fpp_guard_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module fpp_guard_props
  import fpp_pkg::*;
#(
  parameter int BIT_CYC = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] prot_ctrl_byte,
  input wire logic par_req,
  input wire logic [1:0] par_op,
  input wire logic par_boot_sel,
  input wire logic [15:0] par_addr,
  input wire logic par_grant,
  input wire logic par_refuse,
  input wire logic [15:0] erase_base,
  input wire logic [15:0] erase_top,
  input wire logic test_read_req,
  input wire logic test_grant,
  input wire logic test_refuse,
  input wire logic ser_wr_req,
  input wire logic [15:0] ser_wr_addr,
  input wire logic ser_wr_refuse,
  input wire logic cmd_valid,
  input wire logic port0_bit7,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  // ----------------------------------------
  // clocking
  // ----------------------------------------
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (rst);

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_par_one_answer: assert property (par_req |=> par_grant != par_refuse)
    else $error("parallel request not answered exactly once");
  a_par_no_answer: assert property (!par_req |=> !par_grant && !par_refuse)
    else $error("parallel answer without request");
  a_prot_blocks_par: assert property (par_req && $stable(prot_ctrl_byte) && prot_ctrl_byte[1:0] != 2'h3
    && prot_ctrl_byte[3:2] != 2'h0 |=> par_refuse) else $error("protected flash access granted");
  a_level2_test: assert property (test_read_req && $stable(prot_ctrl_byte) && !prot_ctrl_byte[1]
    && prot_ctrl_byte[3:2] != 2'h0 |=> test_refuse && !test_grant) else $error("test read granted at level 2");
  a_test_grant_low: assert property (test_read_req && $stable(prot_ctrl_byte) && prot_ctrl_byte[1]
    |=> test_grant && !test_refuse) else $error("test read refused below level 2");
  a_boot_low_addr: assert property (par_req && par_boot_sel && par_addr < BOOT_BASE |=> par_refuse)
    else $error("boot access below boot base granted");
  a_boot_erase_span: assert property (par_req && par_op == OP_ERASE && par_boot_sel && par_addr >= BOOT_BASE
    |=> !par_grant || (erase_base == BOOT_BASE && erase_top == BOOT_TOP)) else $error("boot erase span wrong");
  a_ser_boot_write: assert property (ser_wr_req && ser_wr_addr >= BOOT_BASE |=> ser_wr_refuse)
    else $error("serial write to boot area accepted");
  a_busy_on_cmd: assert property (cmd_valid |-> ##[0:2] port0_bit7)
    else $error("busy not raised for pending command");
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero without read");

  // ----------------------------------------
  // covers
  // ----------------------------------------
  c_boot_erase: cover property (par_req && par_op == OP_ERASE && par_boot_sel ##1 par_grant);
  c_test_refuse: cover property (test_read_req ##1 test_refuse);
  c_cmd_busy: cover property (cmd_valid ##[1:2] port0_bit7);
endmodule // fpp_guard_props

bind fpp_flash_guard fpp_guard_props #(.BIT_CYC(BIT_CYC)) props (.clk(clk), .rst(rst),
  .prot_ctrl_byte(prot_ctrl_byte), .par_req(par_req), .par_op(par_op), .par_boot_sel(par_boot_sel),
  .par_addr(par_addr), .par_grant(par_grant), .par_refuse(par_refuse), .erase_base(erase_base),
  .erase_top(erase_top), .test_read_req(test_read_req), .test_grant(test_grant), .test_refuse(test_refuse),
  .ser_wr_req(ser_wr_req), .ser_wr_addr(ser_wr_addr), .ser_wr_refuse(ser_wr_refuse), .cmd_valid(cmd_valid),
  .port0_bit7(port0_bit7), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
`default_nettype wire

// *** fpp_prog_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module fpp_prog_model #(
  parameter int BIT_CYC = 8
) (
  input wire logic clk,
  output logic sclk,
  output logic rxd,
  input wire logic txd
);
  // ----------------------------------------
  // idle levels
  // ----------------------------------------
  // strap levels
  initial begin
    sclk = 1'h0; // clock stands low outside frames
    rxd = 1'h1; // line idles high as with a pull-up
  end

  // ----------------------------------------
  // clocked byte exchange, lsb first
  // ----------------------------------------
  // programmer drives clock
  task automatic xfer(input logic [7:0] d, output logic [7:0] q);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      rxd <= d[i];
      repeat (3) @(posedge clk);
      #1 q[i] = txd; // settled well after the last falling edge
      @(posedge clk);
      sclk <= 1'h1;
      repeat (3) @(posedge clk);
      sclk <= 1'h0;
    end
    @(posedge clk);
    rxd <= 1'h1;
  endtask

  // ----------------------------------------
  // asynchronous frame, 8N1 lsb first
  // ----------------------------------------
  // second variant
  task automatic uart(input logic [7:0] d);
    logic [9:0] f;
    f = {1'h1, d, 1'h0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      rxd <= f[i];
      repeat (BIT_CYC - 1) @(posedge clk);
    end
  endtask
endmodule // fpp_prog_model
`default_nettype wire

// *** test_flash_protect_and_prog_mode_entry.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_flash_protect_and_prog_mode_entry;
  import fpp_pkg::*;
  localparam int BITC = 8;
  logic clk = 1'h0, rst = 1'h1, boot_mode_select_pin = 1'h0, program_select_input = 1'h1, port3_bit2 = 1'h1;
  logic [7:0] prot_ctrl_byte = 8'h0F, reg_addr = 8'h00, reg_wdata = 8'h00, cmd_byte, reg_rdata, last_cmd, rx, st;
  logic [55:0] stored_id = 56'h13_579B_DF24_68AC;
  logic flash_blank = 1'h0, par_req = 1'h0, par_boot_sel = 1'h0, test_read_req = 1'h0, ser_wr_req = 1'h0;
  logic cmd_ack = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
  logic [1:0] par_op = 2'h0;
  logic [15:0] par_addr = 16'h0000, ser_wr_addr = 16'h0000, erase_base, erase_top;
  logic sclk, rxd, txd, busy, par_grant, par_refuse, test_grant, test_refuse;
  logic ser_wr_grant, ser_wr_refuse, cmd_valid, id_reject;
  int bad_count = 0, checks_done = 0, cmd_count = 0, rej_count = 0;

  // ----------------------------------------
  // design and programmer
  // ----------------------------------------
  fpp_flash_guard #(.BIT_CYC(BITC)) dut (.clk(clk), .rst(rst), .boot_mode_select_pin(boot_mode_select_pin),
    .program_select_input(program_select_input), .port3_bit2(port3_bit2), .serial_clock_2_pin(sclk),
    .port0_bit4(rxd), .serial_out_2_pin(txd), .port0_bit7(busy), .prot_ctrl_byte(prot_ctrl_byte),
    .stored_id(stored_id), .flash_blank(flash_blank), .par_req(par_req), .par_op(par_op),
    .par_boot_sel(par_boot_sel), .par_addr(par_addr), .par_grant(par_grant), .par_refuse(par_refuse),
    .erase_base(erase_base), .erase_top(erase_top), .test_read_req(test_read_req), .test_grant(test_grant),
    .test_refuse(test_refuse), .ser_wr_req(ser_wr_req), .ser_wr_addr(ser_wr_addr), .ser_wr_grant(ser_wr_grant),
    .ser_wr_refuse(ser_wr_refuse), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .cmd_ack(cmd_ack),
    .id_reject(id_reject), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));
  fpp_prog_model #(.BIT_CYC(BITC)) model (.clk(clk), .sclk(sclk), .rxd(rxd), .txd(txd));

  // clock and watchdog
  initial begin
    forever #20 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    complete_run();
  end

  // counts command and reject pulses
  always @(posedge clk) begin
    if (cmd_valid === 1'h1) begin
      cmd_count <= cmd_count + 1;
      last_cmd <= cmd_byte;
    end
    if (id_reject === 1'h1) begin
      rej_count <= rej_count + 1;
    end
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic reboot(input logic pin, input logic ps);
    @(posedge clk);
    rst <= 1'h1;
    boot_mode_select_pin <= pin;
    program_select_input <= ps;
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    repeat (2) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'h0;
    #1 d = reg_rdata;
  endtask
  task automatic mode_lvl(input logic [1:0] m, input logic [1:0] l);
    rd(REG_STATUS, st);
    chk("mode", m, st[1:0]);
    chk("level", l, st[3:2]);
  endtask
  task automatic par(input logic [1:0] op, input logic b, input logic [15:0] a, input logic g);
    @(posedge clk);
    par_req <= 1'h1;
    par_op <= op;
    par_boot_sel <= b;
    par_addr <= a;
    @(posedge clk);
    par_req <= 1'h0;
    #1 chk("par_grant", g, par_grant);
    chk("par_refuse", !g, par_refuse);
  endtask
  task automatic tread(input logic g);
    @(posedge clk);
    test_read_req <= 1'h1;
    @(posedge clk);
    test_read_req <= 1'h0;
    #1 chk("test_grant", g, test_grant);
    chk("test_refuse", !g, test_refuse);
  endtask
  task automatic swr(input logic [15:0] a, input logic g);
    @(posedge clk);
    ser_wr_req <= 1'h1;
    ser_wr_addr <= a;
    @(posedge clk);
    ser_wr_req <= 1'h0;
    #1 chk("ser_wr_grant", g, ser_wr_grant);
    chk("ser_wr_refuse", !g, ser_wr_refuse);
  endtask
  task automatic setp(input logic [7:0] b);
    @(posedge clk);
    prot_ctrl_byte <= b;
    repeat (2) @(posedge clk);
  endtask
  task automatic send_id(input logic [7:0] flip);
    for (int i = 0; i < 7; i++) begin
      model.xfer(stored_id[8*i+:8] ^ ((i == 3) ? flip : 8'h00), rx);
    end
    settle(6);
  endtask
  task automatic ack();
    @(posedge clk);
    cmd_ack <= 1'h1;
    @(posedge clk);
    cmd_ack <= 1'h0;
  endtask
  task automatic complete_run();
    if (bad_count == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    reboot(1'h1, 1'h1);
    mode_lvl(2'h1, 2'h0);
    par(OP_READ, 1'h0, 16'h1234, 1'h1);
    par(OP_PROG, 1'h1, 16'hF800, 1'h1);
    par(OP_ERASE, 1'h1, 16'hF123, 1'h1);
    chk("erase_base", BOOT_BASE, erase_base);
    chk("erase_top", BOOT_TOP, erase_top);
    par(OP_PROG, 1'h1, 16'hEFFF, 1'h0);
    tread(1'h1);
    setp(8'h0E);
    mode_lvl(2'h1, 2'h1);
    par(OP_READ, 1'h0, 16'h1234, 1'h0);
    par(OP_PROG, 1'h0, PROT_ADDR, 1'h0);
    tread(1'h1);
    setp(8'h0C);
    mode_lvl(2'h1, 2'h2);
    tread(1'h0);
    par(OP_ERASE, 1'h1, 16'hF000, 1'h0);
    setp(8'h00);
    mode_lvl(2'h1, 2'h0);
    par(OP_PROG, 1'h0, PROT_ADDR, 1'h1);
    reboot(1'h0, 1'h1);
    mode_lvl(2'h0, 2'h0);
    par(OP_READ, 1'h0, 16'h1234, 1'h0);
    reboot(1'h1, 1'h0);
    mode_lvl(2'h2, 2'h0);
    swr(16'h1000, 1'h0);
    send_id(8'h40);
    chk("id_reject", 1, rej_count);
    chk("cmd_count", 0, cmd_count);
    swr(16'h1000, 1'h0);
    send_id(8'h00);
    rd(REG_STATUS, st);
    chk("id_ok", 1, st[ST_ID_OK_BIT]);
    chk("id_reject", 1, rej_count);
    chk("id_wait", 0, st[ST_ID_WAIT_BIT]);
    model.xfer(8'h5A, rx);
    settle(6);
    chk("cmd_count", 1, cmd_count);
    chk("cmd_byte", 8'h5A, last_cmd);
    chk("busy", 1, busy);
    rd(REG_STATUS, st);
    chk("st_busy", 1, st[ST_BUSY_BIT]);
    ack();
    settle(3);
    chk("busy", 0, busy);
    swr(16'h1000, 1'h1);
    swr(BOOT_BASE, 1'h0);
    wr(REG_TXDATA, 8'hA5);
    model.xfer(8'hC3, rx);
    chk("tx_byte", 8'hA5, rx);
    ack();
    wr(REG_CTRL, 8'h01);
    rd(REG_CTRL, st);
    chk("ctrl", 8'h01, st);
    model.uart(8'h3C);
    settle(6);
    chk("cmd_count", 3, cmd_count);
    chk("cmd_byte", 8'h3C, last_cmd);
    wr(8'h44, 8'hFF);
    rd(8'h44, st);
    chk("unmapped", 0, st);
    // blank flash skips the identifier check
    @(posedge clk);
    flash_blank <= 1'h1;
    reboot(1'h1, 1'h0);
    swr(16'h1000, 1'h1);
    complete_run();
  end
endmodule // test_flash_protect_and_prog_mode_entry
`default_nettype wire
